//--- adc_port_pkg.sv
package adc_port_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int RES_W  = 10;
  localparam int DATA_W = 8;
  localparam int SYNC_W = 13;

  // ----------------------------------------------------------------
  // Control byte fields
  // ----------------------------------------------------------------
  localparam int       CFG_ACQ_BIT   = 5;
  localparam int       CFG_CLK_LSB   = 6;
  localparam logic [1:0] CLK_MODE_EXT = 2'h3;
  localparam logic [7:0] CFG_RESET    = 8'hC0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int REF_CLK_MHZ  = 125;
  localparam int INT_CLK_NS   = 250;
  localparam int INT_CLK_DIV  = (INT_CLK_NS * REF_CLK_MHZ) / 1000;
  localparam int ACQ_TICKS    = 3;
  localparam int CONV_TICKS   = 13;
  localparam int TICK_CNT_W   = 4;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_IDLE    = 2'b00,
    SEQ_ACQ_INT = 2'b01,
    SEQ_ACQ_EXT = 2'b10,
    SEQ_CONV    = 2'b11
  } seq_state_e;
endpackage

//--- conv_seq_if.sv
`timescale 1ns/1ps
interface conv_seq_if;
  logic                      tick;
  logic                      start_int;
  logic                      start_ext;
  logic                      start_conv;
  logic                      conv_done;
  logic                      acq_ext;
  logic                      busy;

  modport seq (input tick, input start_int, input start_ext, input start_conv,
               output conv_done, output acq_ext, output busy);
  modport ctl (output tick, output start_int, output start_ext, output start_conv,
               input conv_done, input acq_ext, input busy);
endinterface

//--- conv_sequencer.sv
`timescale 1ns/1ps
module conv_sequencer
  import adc_port_pkg::*;
(
  input  wire logic ref_clk, // System clock
  input  wire logic reset,   // Synchronous reset
  conv_seq_if.seq   sq       // Control link
);
  import adc_port_pkg::*;

  seq_state_e                  state_q;
  seq_state_e                  state_d;
  logic [TICK_CNT_W-1:0]       cnt_q;
  logic [TICK_CNT_W-1:0]       cnt_d;
  logic                        last_acq;
  logic                        last_conv;

  // ----------------------------------------------------------------
  // Terminal counts
  // ----------------------------------------------------------------
  assign last_acq  = sq.tick && (cnt_q == TICK_CNT_W'(ACQ_TICKS - 1));
  assign last_conv = sq.tick && (cnt_q == TICK_CNT_W'(CONV_TICKS - 1));
  assign sq.conv_done = (state_q == SEQ_CONV) && last_conv && !sq.start_int && !sq.start_ext;
  assign sq.acq_ext   = (state_q == SEQ_ACQ_EXT);
  assign sq.busy      = (state_q != SEQ_IDLE);

  // Next state; a new start aborts whatever runs
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    if (sq.start_int) begin
      state_d = SEQ_ACQ_INT;
      cnt_d   = '0;
    end else if (sq.start_ext) begin
      state_d = SEQ_ACQ_EXT;
      cnt_d   = '0;
    end else if (sq.start_conv) begin
      state_d = SEQ_CONV;
      cnt_d   = '0;
    end else begin
      case (state_q)
        SEQ_ACQ_INT: begin
          if (last_acq) begin
            state_d = SEQ_CONV;
            cnt_d   = '0;
          end else if (sq.tick) begin
            cnt_d = cnt_q + TICK_CNT_W'(1);
          end
        end
        SEQ_CONV: begin
          if (last_conv) begin
            state_d = SEQ_IDLE;
            cnt_d   = '0;
          end else if (sq.tick) begin
            cnt_d = cnt_q + TICK_CNT_W'(1);
          end
        end
        SEQ_IDLE, SEQ_ACQ_EXT: begin
          cnt_d = '0;
        end
        default: begin
          state_d = SEQ_IDLE;
          cnt_d   = '0;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= SEQ_IDLE;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [4:0] ticks_in_conv_q;
  always_ff @(posedge ref_clk) begin
    if (reset || state_q != SEQ_CONV) begin
      ticks_in_conv_q <= '0;
    end else if (sq.tick) begin
      ticks_in_conv_q <= ticks_in_conv_q + 5'h01;
    end
  end

  property p_conv_len;
    @(posedge ref_clk) disable iff (reset)
      sq.conv_done |-> ticks_in_conv_q == 5'(CONV_TICKS - 1);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_acq_len;
    @(posedge ref_clk) disable iff (reset)
      (state_q == SEQ_ACQ_INT && cnt_q == 4'h2 && sq.tick && !sq.start_int && !sq.start_ext && !sq.start_conv)
      |=> state_q == SEQ_CONV && cnt_q == 4'h0;
  endproperty
  a_acq_len: assert property (p_acq_len) else $error("internal acquisition not three ticks");

  c_conv_done: cover property (@(posedge ref_clk) disable iff (reset) sq.conv_done);
endmodule

//--- adc_host_port.sv
`timescale 1ns/1ps
module adc_host_port
  import adc_port_pkg::*;
#(
  parameter int CLK_DIV = INT_CLK_DIV // Internal converter clock divider
)(
  input  wire logic                             ref_clk,          // System clock
  input  wire logic                             reset,            // Synchronous reset
  input  wire logic                             cs_n,             // Chip select, active low
  input  wire logic                             rd_n,             // Read strobe, active low
  input  wire logic                             wr_n,             // Write strobe, active low
  input  wire logic                             high_byte_select, // Upper result bits select
  input  wire logic                             conv_clk_pin,     // External converter clock
  input  wire logic [adc_port_pkg::DATA_W-1:0]  data_in,          // Data bus input
  output logic      [adc_port_pkg::DATA_W-1:0]  data_out,         // Data bus output
  output logic                                  data_oe,          // Data bus drive enable
  output logic                                  done_n_out,       // Done flag, active low
  output logic                                  done_oe,          // Done flag drive enable
  input  wire logic [adc_port_pkg::RES_W-1:0]   sample_in,        // Result from converter core
  output logic      [adc_port_pkg::DATA_W-1:0]  cfg_byte          // Current control byte
);
  import adc_port_pkg::*;

  conv_seq_if sq ();

  logic [SYNC_W-1:0]  meta_q;
  logic [SYNC_W-1:0]  sync_q;
  logic [4:0]         prev_q;
  logic               cs_s;
  logic               rd_s;
  logic               wr_s;
  logic               hbs_s;
  logic               clk_s;
  logic [DATA_W-1:0]  din_s;
  logic               sel;
  logic               rd_fall;
  logic               rd_rise;
  logic               wr_rise;
  logic               clk_fall;
  logic               new_acq;
  logic               int_clk_mode;
  logic [7:0]         div_q;
  logic               div_tick;
  logic [DATA_W-1:0]  cfg_q;
  logic [RES_W-1:0]   result_q;
  logic               reading_q;
  logic               done_n_q;
  logic [DATA_W-1:0]  byte_sel;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      meta_q <= {5'h1F, 8'h00};
      sync_q <= {5'h1F, 8'h00};
      prev_q <= 5'h1F;
    end else begin
      meta_q <= {cs_n, rd_n, wr_n, high_byte_select, conv_clk_pin, data_in};
      sync_q <= meta_q;
      prev_q <= sync_q[SYNC_W-1:DATA_W];
    end
  end

  assign {cs_s, rd_s, wr_s, hbs_s, clk_s, din_s} = sync_q;
  assign sel      = !cs_s;
  assign rd_fall  = sel && prev_q[3] && !rd_s;
  assign rd_rise  = !prev_q[3] && rd_s;
  assign wr_rise  = sel && !prev_q[2] && wr_s;
  assign clk_fall = prev_q[0] && !clk_s;

  // ----------------------------------------------------------------
  // Converter clock: pin falling edges or internal divider
  // ----------------------------------------------------------------
  assign int_clk_mode = cfg_q[CFG_CLK_LSB+1:CFG_CLK_LSB] != CLK_MODE_EXT;
  assign div_tick     = (div_q == 8'(CLK_DIV - 1));

  always_ff @(posedge ref_clk) begin
    if (reset || div_tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  assign sq.tick = int_clk_mode ? div_tick : clk_fall;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  assign new_acq       = wr_rise && !(sq.acq_ext && !din_s[CFG_ACQ_BIT]);
  assign sq.start_int  = new_acq && !din_s[CFG_ACQ_BIT];
  assign sq.start_ext  = new_acq && din_s[CFG_ACQ_BIT];
  assign sq.start_conv = wr_rise && sq.acq_ext && !din_s[CFG_ACQ_BIT];

  // Control byte register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cfg_q <= CFG_RESET;
    end else if (wr_rise) begin
      cfg_q <= din_s;
    end
  end

  conv_sequencer u_seq (
    .ref_clk (ref_clk),
    .reset   (reset),
    .sq      (sq)
  );

  // ----------------------------------------------------------------
  // Result, read window and done flag
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      result_q <= '0;
    end else if (sq.conv_done) begin
      result_q <= sample_in;
    end
  end

  // Read window opens on strobe fall, closes on rise or deselect
  always_ff @(posedge ref_clk) begin
    if (reset || !sel || rd_rise) begin
      reading_q <= 1'b0;
    end else if (rd_fall) begin
      reading_q <= 1'b1;
    end
  end

  // Done flag; completion wins over a same-cycle read clear, a write aborts it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      done_n_q <= 1'b1;
    end else if (sq.conv_done) begin
      done_n_q <= 1'b0;
    end else if (rd_fall || wr_rise) begin
      done_n_q <= 1'b1;
    end
  end

  // Byte multiplexer for the shared low lines
  assign byte_sel = hbs_s ? {6'h00, result_q[RES_W-1:DATA_W]} : result_q[DATA_W-1:0];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      data_out <= 8'h00;
    end else begin
      data_out <= byte_sel;
    end
  end

  // Drive enables collapse while deselected
  assign data_oe    = sel && reading_q;
  assign done_oe    = sel;
  assign done_n_out = done_n_q;
  assign cfg_byte   = cfg_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_tristate;
    @(posedge ref_clk) disable iff (reset)
      cs_s |-> !data_oe && !done_oe;
  endproperty
  a_tristate: assert property (p_tristate) else $error("outputs driven while deselected");

  property p_byte_mux;
    @(posedge ref_clk) disable iff (reset)
      ##1 (hbs_s && $stable(hbs_s) && $stable(result_q)) |->
        data_out == {6'h00, result_q[9:8]};
  endproperty
  a_byte_mux: assert property (p_byte_mux) else $error("high byte not on low lines");

  property p_low_byte;
    @(posedge ref_clk) disable iff (reset)
      ##1 (!hbs_s && $stable(hbs_s) && $stable(result_q)) |-> data_out == result_q[7:0];
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("low byte wrong");

  property p_read_drive;
    @(posedge ref_clk) disable iff (reset)
      (rd_fall && !rd_rise) ##1 sel |-> data_oe;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read did not drive bus");

  property p_done_set;
    @(posedge ref_clk) disable iff (reset)
      sq.conv_done |=> !done_n_q;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set");

  property p_done_clear;
    @(posedge ref_clk) disable iff (reset)
      (!done_n_q && rd_fall && !sq.conv_done) |=> done_n_q;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done flag not cleared by read");

  property p_cfg_capture;
    @(posedge ref_clk) disable iff (reset)
      wr_rise |=> cfg_q == $past(din_s);
  endproperty
  a_cfg_capture: assert property (p_cfg_capture) else $error("control byte not captured");

  property p_ext_to_conv;
    @(posedge ref_clk) disable iff (reset)
      (wr_rise && sq.acq_ext && !din_s[CFG_ACQ_BIT]) |=> sq.busy && !sq.acq_ext ##0 u_seq.state_q == SEQ_CONV;
  endproperty
  a_ext_to_conv: assert property (p_ext_to_conv) else $error("external acquisition not ended");

  property p_done_wr_clear;
    @(posedge ref_clk) disable iff (reset)
      (!done_n_q && wr_rise && !sq.conv_done) |=> done_n_q;
  endproperty
  a_done_wr_clear: assert property (p_done_wr_clear) else $error("done flag not cleared by write");

  // Only a finishing conversion may move the flag while deselected
  property p_ignore_deselect;
    @(posedge ref_clk) disable iff (reset)
      cs_s |=> $stable(cfg_q) && ((done_n_q == $past(done_n_q)) || $past(sq.conv_done));
  endproperty
  a_ignore_deselect: assert property (p_ignore_deselect) else $error("strobe acted while deselected");

  c_int_acq: cover property (@(posedge ref_clk) disable iff (reset) sq.start_int ##[1:600] sq.conv_done);
  c_ext_acq: cover property (@(posedge ref_clk) disable iff (reset) sq.start_ext ##[1:600] sq.start_conv);
  c_read_hi: cover property (@(posedge ref_clk) disable iff (reset) data_oe && hbs_s);
endmodule

//--- host_model.sv
`timescale 1ns/1ps
module host_model (
  input  wire logic                            ref_clk,          // System clock
  input  wire logic [adc_port_pkg::DATA_W-1:0] data_out,         // Device bus output
  input  wire logic                            data_oe,          // Device bus enable
  output logic                                 cs_n,             // Chip select
  output logic                                 rd_n,             // Read strobe
  output logic                                 wr_n,             // Write strobe
  output logic                                 high_byte_select, // Upper bits select
  output logic                                 conv_clk_pin,     // Converter clock
  output logic [adc_port_pkg::DATA_W-1:0]      bus               // Resolved data bus
);
  import adc_port_pkg::*;
  logic [DATA_W-1:0] host_d;
  logic [DATA_W-1:0] last_q;
  logic              host_oe;
  logic              clk_run;

  // Released bus shows a changing pattern
  assign bus = data_oe ? data_out : (host_oe ? host_d : ~last_q);

  always @(posedge ref_clk) begin
    last_q <= bus;
  end

  // Converter clock runs only when asked, else held low
  always #32 conv_clk_pin = clk_run & ~conv_clk_pin;

  initial begin
    {cs_n, rd_n, wr_n} = 3'h7;
    high_byte_select = 1'b0;
    conv_clk_pin = 1'b0;
    clk_run = 1'b0;
    host_oe = 1'b0;
    host_d = 8'h00;
    last_q = 8'h00;
  end

  // Pin cycle helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic sel(input logic v);
    cyc(1);
    cs_n = v;
    cyc(4);
  endtask

  task automatic write(input logic [DATA_W-1:0] b);
    cyc(1);
    host_d = b;
    host_oe = 1'b1;
    cyc(4);
    wr_n = 1'b0;
    cyc(4);
    wr_n = 1'b1;
    cyc(4);
    host_oe = 1'b0;
  endtask

  task automatic read_start(input logic hb);
    cyc(1);
    high_byte_select = hb;
    rd_n = 1'b0;
    cyc(5);
  endtask

  task automatic set_hb(input logic hb);
    cyc(1);
    high_byte_select = hb;
    cyc(5);
  endtask

  task automatic read_end;
    cyc(1);
    rd_n = 1'b1;
    cyc(5);
  endtask
endmodule

//--- adc_byte_parallel_host_port_bench.sv
`timescale 1ns/1ps
module adc_byte_parallel_host_port_bench;
  import adc_port_pkg::*;
  localparam int DIV   = 2;
  localparam int EXT_T = 8;

  logic              ref_clk;
  logic              reset;
  logic              cs_n;
  logic              rd_n;
  logic              wr_n;
  logic              high_byte_select;
  logic              conv_clk_pin;
  logic [DATA_W-1:0] bus;
  logic [DATA_W-1:0] data_out;
  logic              data_oe;
  logic              done_n_out;
  logic              done_oe;
  logic [RES_W-1:0]  sample_in;
  logic [DATA_W-1:0] cfg_byte;
  int                fails;
  int                tests_run;
  int                exp_q[$];
  logic [4:0]        ext_bits;

  host_model i_host (.ref_clk(ref_clk), .data_out(data_out), .data_oe(data_oe), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .high_byte_select(high_byte_select), .conv_clk_pin(conv_clk_pin), .bus(bus));

  adc_host_port #(.CLK_DIV(DIV)) i_dut (.ref_clk(ref_clk), .reset(reset), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .high_byte_select(high_byte_select), .conv_clk_pin(conv_clk_pin), .data_in(bus),
    .data_out(data_out), .data_oe(data_oe), .done_n_out(done_n_out), .done_oe(done_oe),
    .sample_in(sample_in), .cfg_byte(cfg_byte));

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Comparison and verdict
  task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask

  task automatic end_sim;
    if (fails == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Bounded wait for the done flag, k ticks of period t
  task automatic wait_done(input int k, input int t);
    int n;
    n = 0;
    while (done_n_out !== 1'b0 && n < k * t + 10) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("done_n", 10'h0, 10'(done_n_out));
    chk("conv_time", 10'h1, 10'(n >= (k - 1) * t - 4));
    if (done_n_out !== 1'b0)
      end_sim();
  endtask

  // Read both bytes and compare with the model
  task automatic do_read;
    int e;
    e = exp_q.pop_front();
    i_host.read_start(1'b0);
    chk("data_oe", 10'h1, 10'(data_oe));
    chk("done_clr", 10'h1, 10'(done_n_out));
    chk("done_oe", 10'h1, 10'(done_oe));
    chk("low_byte", 10'(e & 8'hFF), 10'(data_out));
    i_host.set_hb(1'b1);
    chk("high_byte", 10'(e >> 8), 10'(data_out));
    i_host.read_end();
    chk("data_oe_rel", 10'h0, 10'(data_oe));
  endtask

  // One conversion started by a control byte
  task automatic conv(input logic [7:0] cfg, input int k, input int t, input bit rd);
    sample_in = 10'($urandom);
    if (rd)
      exp_q.push_back(int'(sample_in));
    i_host.write(cfg);
    chk("cfg", 10'(cfg), 10'(cfg_byte));
    wait_done(k, t);
    if (rd)
      do_read();
  endtask

  // Main sequence
  initial begin
    fails = 0;
    tests_run = 0;
    reset = 1'b1;
    sample_in = 10'h000;
    void'($urandom(32'hFB3D1F11));
    repeat (6) @(posedge ref_clk);
    #1 reset = 1'b0;
    chk("cfg_rst", 10'(CFG_RESET), 10'(cfg_byte));
    chk("done_rst", 10'h1, 10'(done_n_out));
    i_host.sel(1'b0);
    for (int i = 0; i < 4; i++) begin
      conv({3'b000, 5'($urandom)}, ACQ_TICKS + CONV_TICKS, DIV, 1'b1);
    end
    i_host.clk_run = 1'b1;
    conv(8'hC0, ACQ_TICKS + CONV_TICKS, EXT_T, 1'b1);
    i_host.clk_run = 1'b0;
    conv(8'h00, ACQ_TICKS + CONV_TICKS, DIV, 1'b0);
    ext_bits = 5'($urandom);
    i_host.write({3'b001, ext_bits});
    chk("done_wr_clr", 10'h1, 10'(done_n_out));
    conv({3'b000, ext_bits}, CONV_TICKS, DIV, 1'b1);
    i_host.sel(1'b1);
    chk("done_oe_off", 10'h0, 10'(done_oe));
    i_host.write(8'($urandom));
    chk("cfg_kept", 10'({3'b000, ext_bits}), 10'(cfg_byte));
    i_host.read_start(1'b0);
    chk("data_oe_off", 10'h0, 10'(data_oe));
    i_host.read_end();
    end_sim();
  end
endmodule
